// ### rps_pkg.sv
// rps_pkg: constants, offsets, field positions and types of the
// reference pulse scaler.
// assumes: included first in compile order, nothing imported elsewhere.
package rps_pkg;
    // multiplier value limits and reset value
    localparam int unsigned MULT_W   = 7;
    localparam logic [6:0]  MULT_MIN = 7'h01;
    localparam logic [6:0]  MULT_MAX = 7'h64;
    localparam logic [6:0]  MULT_RST = 7'h01;

    // gear numerator and denominator limits and reset values
    localparam int unsigned GEAR_W   = 31;
    localparam logic [30:0] GEAR_MIN = 31'h0000_0001;
    localparam logic [30:0] GEAR_MAX = 31'h4000_0000;
    localparam logic [30:0] NUM_RST  = 31'h0000_0004;
    localparam logic [30:0] DEN_RST  = 31'h0000_0001;

    // ratio window: 1/RATIO_LO_DIV <= num/den <= RATIO_HI
    localparam int unsigned RATIO_LO_DIV = 1000;
    localparam int unsigned RATIO_HI     = 4000;
    localparam int unsigned CMP_W        = 43;

    // datapath widths
    localparam int unsigned UNIT_W = 16;
    localparam int unsigned PROD_W = 48;
    localparam int unsigned CNT_W  = 6;
    localparam logic [5:0]  DIV_STEPS = 6'h2f;

    // register offsets (word index on the plain port)
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_MULT  = 4'h1;
    localparam logic [3:0] OFS_NUM   = 4'h2;
    localparam logic [3:0] OFS_DEN   = 4'h3;
    localparam logic [3:0] OFS_STAT  = 4'h4;
    localparam logic [3:0] OFS_ISTAT = 4'h5;
    localparam logic [3:0] OFS_IMASK = 4'h6;

    // field positions
    localparam int unsigned CTRL_RESTART = 0;
    localparam int unsigned ST_ACTIVE    = 0;
    localparam int unsigned ST_PERR      = 1;
    localparam int unsigned ST_BUSY      = 2;
    localparam int unsigned EV_PERR      = 0;
    localparam int unsigned EV_SWITCH    = 1;
    localparam int unsigned EV_OVF       = 2;
    localparam int unsigned EV_W         = 3;
    localparam logic [2:0]  IMASK_RST    = 3'h0;

    // divider sequencer states
    typedef enum logic [2:0] {
        DIV_IDLE = 3'b001,
        DIV_RUN  = 3'b010,
        DIV_FIX  = 3'b100
    } rps_div_state_t;
endpackage

// ### rps_div_if.sv
// rps_div_if: request and answer between the scaler and its gear divider.
// assumes: one clock domain, the scaler drives start for one cycle only.
interface rps_div_if;
    logic                                start;
    logic                                clear;
    logic signed [rps_pkg::UNIT_W-1:0]   units;
    logic        [rps_pkg::GEAR_W-1:0]   num;
    logic        [rps_pkg::GEAR_W-1:0]   den;
    logic                                busy;
    logic                                done;
    logic signed [rps_pkg::PROD_W-1:0]   quot;

    modport host (output start, clear, units, num, den,
                  input  busy, done, quot);
    modport div  (input  start, clear, units, num, den,
                  output busy, done, quot);
endinterface

// ### rps_gear_div.sv
// rps_gear_div: floor division of units*num+remainder by den, one bit per
// clock, keeping the remainder for the next batch.
// assumes: num and den stay stable while busy; den is never zero.
module rps_gear_div (
    input  wire logic clk,       // drive clock
    input  wire logic rst_n,     // async reset, active low
    rps_div_if.div    bus        // request and answer
);
    rps_pkg::rps_div_state_t         stQ;
    logic [rps_pkg::CNT_W-1:0]       cntQ;
    logic [rps_pkg::PROD_W-1:0]      dvdQ;
    logic [rps_pkg::PROD_W-1:0]      quoQ;
    logic [rps_pkg::GEAR_W:0]        partQ;
    logic [rps_pkg::GEAR_W-1:0]      remQ;
    logic                            negQ;
    logic                            doneQ;
    logic signed [rps_pkg::PROD_W-1:0] quotQ;

    // operand forming; the product fits because units and num are bounded
    wire signed [47:0] unitsX = 48'(bus.units);
    wire signed [47:0] numX   = $signed({17'h0_0000, bus.num});
    wire signed [47:0] remX   = $signed({17'h0_0000, remQ});
    wire signed [47:0] sumW   = unitsX * numX + remX;
    wire        [47:0] magW   = sumW[47] ? 48'(-sumW) : 48'(sumW);
    wire        [31:0] trial  = {partQ[30:0], dvdQ[47]};
    wire               geW    = trial >= {1'b0, bus.den};
    wire        [31:0] partN  = geW ? trial - {1'b0, bus.den} : trial;
    wire               remZero = (partQ == 32'h0000_0000);

    assign bus.busy = (stQ != rps_pkg::DIV_IDLE);
    assign bus.done = doneQ;
    assign bus.quot = quotQ;

    // sequencer: load, shift-subtract, then floor correction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stQ   <= rps_pkg::DIV_IDLE;
            cntQ  <= '0;
            dvdQ  <= '0;
            quoQ  <= '0;
            partQ <= '0;
            remQ  <= '0;
            negQ  <= 1'b0;
            doneQ <= 1'b0;
            quotQ <= '0;
        end else begin
            doneQ <= 1'b0;
            case (stQ)
                rps_pkg::DIV_IDLE: begin
                    if (bus.clear) begin
                        remQ <= '0;
                    end else if (bus.start) begin
                        dvdQ  <= magW;
                        negQ  <= sumW[47];
                        partQ <= '0;
                        quoQ  <= '0;
                        cntQ  <= rps_pkg::DIV_STEPS;
                        stQ   <= rps_pkg::DIV_RUN;
                    end
                end
                rps_pkg::DIV_RUN: begin
                    partQ <= partN;
                    quoQ  <= {quoQ[46:0], geW};
                    dvdQ  <= {dvdQ[46:0], 1'b0};
                    cntQ  <= cntQ - 6'h01;
                    if (cntQ == 6'h00) begin
                        stQ <= rps_pkg::DIV_FIX;
                    end
                end
                rps_pkg::DIV_FIX: begin
                    // negative values round toward minus infinity so that the
                    // kept remainder is never negative
                    if (!negQ) begin
                        quotQ <= $signed(quoQ);
                        remQ  <= partQ[30:0];
                    end else if (remZero) begin
                        quotQ <= -$signed(quoQ);
                        remQ  <= '0;
                    end else begin
                        quotQ <= -$signed(quoQ + 48'h0000_0000_0001);
                        remQ  <= bus.den - partQ[30:0];
                    end
                    doneQ <= 1'b1;
                    stQ   <= rps_pkg::DIV_IDLE;
                end
                default: stQ <= rps_pkg::DIV_IDLE;
            endcase
        end
    end

    sequence s_req;
        bus.start && !bus.busy && !bus.clear;
    endsequence
    property p_div_done;
        @(posedge clk) disable iff (!rst_n)
        s_req |-> ##[50:51] bus.done;
    endproperty
    a_div_done: assert property (p_div_done)
        else $error("divider answer missing or early");

    property p_rem_bound;
        @(posedge clk) disable iff (!rst_n)
        !bus.busy |-> (remQ < bus.den);
    endproperty
    a_rem_bound: assert property (p_rem_bound)
        else $error("kept remainder not below denominator");
endmodule

// ### rps_reference_pulse_scaler.sv
// rps_reference_pulse_scaler: multiplies host reference pulses and scales
// them by the electronic gear into encoder pulse increments.
// assumes: pulse inputs synchronous to clk, one pulse per cycle at most;
// register port strobes are one cycle long and never both at once.
//
// Local design decisions: the register addresses and the address-and-strobe port.
module rps_reference_pulse_scaler (
    input  wire logic        clk,            // drive clock, 25 MHz
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic        refPulse,       // one reference pulse
    input  wire logic        refDir,         // 1 = reverse direction
    input  wire logic        selectIn,       // multiplier select level
    input  wire logic        progJogRun,     // program jog utility busy
    input  wire logic        autoTuneRun,    // advanced autotune busy
    input  wire logic [3:0]  regAddr,        // register index
    input  wire logic [31:0] regWdata,       // write data
    input  wire logic        regWr,          // write strobe
    input  wire logic        regRd,          // read strobe
    output logic      [31:0] regRdata,       // read data, cycle after
    output logic             multiplierActiveOut, // multiplier applied
    output logic signed [47:0] encDelta,     // encoder pulse increment
    output logic             encValid,       // encDelta valid pulse
    output logic             paramError,     // gear ratio out of range
    output logic             irq             // level interrupt
);
    localparam int unsigned UW = rps_pkg::UNIT_W;
    localparam int unsigned GW = rps_pkg::GEAR_W;

    // range test shared by the numerator and denominator writes
    function automatic logic gearInRange(input logic [31:0] v);
        gearInRange = (v >= {1'b0, rps_pkg::GEAR_MIN}) &&
                      (v <= {1'b0, rps_pkg::GEAR_MAX});
    endfunction

    rps_div_if divBus ();

    logic [rps_pkg::MULT_W-1:0] multValueQ;
    logic                       multActiveQ;
    logic [GW-1:0]              numStageQ;
    logic [GW-1:0]              denStageQ;
    logic [GW-1:0]              numActQ;
    logic [GW-1:0]              denActQ;
    logic                       loadGearQ;
    logic                       paramErrQ;
    logic signed [UW-1:0]       pendQ;
    logic [rps_pkg::EV_W-1:0]   intStatQ;
    logic [rps_pkg::EV_W-1:0]   intMaskQ;
    logic [31:0]                rdataQ;
    logic signed [47:0]         encDeltaQ;
    logic                       encValidQ;

    // register strobes
    wire wrCtrl  = regWr && (regAddr == rps_pkg::OFS_CTRL);
    wire wrMult  = regWr && (regAddr == rps_pkg::OFS_MULT);
    wire wrNum   = regWr && (regAddr == rps_pkg::OFS_NUM);
    wire wrDen   = regWr && (regAddr == rps_pkg::OFS_DEN);
    wire wrIstat = regWr && (regAddr == rps_pkg::OFS_ISTAT);
    wire wrImask = regWr && (regAddr == rps_pkg::OFS_IMASK);
    wire restartReq = wrCtrl && regWdata[rps_pkg::CTRL_RESTART];
    wire multOk  = (regWdata >= 32'(rps_pkg::MULT_MIN)) &&
                   (regWdata <= 32'(rps_pkg::MULT_MAX));

    // multiplier selection; a utility in progress overrides the select
    wire utilBlock  = progJogRun || autoTuneRun;
    wire multActD   = utilBlock ? 1'b0 : selectIn;
    wire [rps_pkg::MULT_W-1:0] factor =
        multActiveQ ? multValueQ : rps_pkg::MULT_MIN;

    // pulse to reference units; a pulse that would overflow the pending sum is dropped
    wire signed [UW:0] incW = refPulse ?
        (refDir ? -$signed({10'h000, factor}) : $signed({10'h000, factor}))
        : 17'sh0_0000;
    wire divStart = !divBus.busy && (pendQ != 16'sh0000) &&
                    !paramErrQ && !loadGearQ;
    wire signed [UW:0] baseW = divStart ? 17'sh0_0000 : 17'(pendQ);
    wire signed [UW:0] sumW  = baseW + incW;
    wire pendOvf = (sumW[UW] != sumW[UW-1]);
    wire signed [UW-1:0] pendD = pendOvf ? 16'(baseW) : sumW[UW-1:0];

    // ratio window: den <= 1000*num and num <= 4000*den
    wire [rps_pkg::CMP_W-1:0] numLo =
        43'(numActQ) * 43'(rps_pkg::RATIO_LO_DIV);
    wire [rps_pkg::CMP_W-1:0] denHi =
        43'(denActQ) * 43'(rps_pkg::RATIO_HI);
    wire ratioOk = (43'(denActQ) <= numLo) && (43'(numActQ) <= denHi);

    // interrupt events and write-one-to-clear; a new event beats the clear
    wire [rps_pkg::EV_W-1:0] events = {pendOvf && refPulse,
                                       multActD != multActiveQ,
                                       !ratioOk && !paramErrQ};
    wire [rps_pkg::EV_W-1:0] clrBits = wrIstat ?
        regWdata[rps_pkg::EV_W-1:0] : 3'h0;
    wire [rps_pkg::EV_W-1:0] intStatD = (intStatQ & ~clrBits) | events;

    // divider hookup; an error, or a restart that finds the divider idle, drops the carried remainder
    assign divBus.start = divStart;
    assign divBus.clear = loadGearQ || paramErrQ;
    assign divBus.units = pendQ;
    assign divBus.num   = numActQ;
    assign divBus.den   = denActQ;

    rps_gear_div u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (divBus.div)
    );

    // read selection
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (regAddr)
            rps_pkg::OFS_MULT:  rdMux = 32'(multValueQ);
            rps_pkg::OFS_NUM:   rdMux = 32'(numStageQ);
            rps_pkg::OFS_DEN:   rdMux = 32'(denStageQ);
            rps_pkg::OFS_STAT:  rdMux = {29'h0000_0000, divBus.busy,
                                         paramErrQ, multActiveQ};
            rps_pkg::OFS_ISTAT: rdMux = 32'(intStatQ);
            rps_pkg::OFS_IMASK: rdMux = 32'(intMaskQ);
            default:            rdMux = 32'h0000_0000;
        endcase
    end

    // software-written settings; out-of-range values are not taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            multValueQ <= rps_pkg::MULT_RST;
            numStageQ  <= rps_pkg::NUM_RST;
            denStageQ  <= rps_pkg::DEN_RST;
            intMaskQ   <= rps_pkg::IMASK_RST;
        end else begin
            if (wrMult && multOk) begin
                multValueQ <= regWdata[6:0];
            end
            if (wrNum && gearInRange(regWdata)) begin
                numStageQ <= regWdata[30:0];
            end
            if (wrDen && gearInRange(regWdata)) begin
                denStageQ <= regWdata[30:0];
            end
            if (wrImask) begin
                intMaskQ <= regWdata[rps_pkg::EV_W-1:0];
            end
        end
    end

    // gear values take effect only at the restart after reset or command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loadGearQ <= 1'b1;
            numActQ   <= rps_pkg::NUM_RST;
            denActQ   <= rps_pkg::DEN_RST;
            paramErrQ <= 1'b0;
        end else begin
            loadGearQ <= restartReq;
            if (loadGearQ) begin
                numActQ <= numStageQ;
                denActQ <= denStageQ;
            end
            paramErrQ <= !ratioOk;
        end
    end

    // switching takes effect at once: the host keeps pulses quiet around
    // a change, so no pending units are rescaled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            multActiveQ <= 1'b0;
        end else begin
            multActiveQ <= multActD;
        end
    end

    // pending reference units, cleared on restart or error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendQ <= '0;
        end else if (loadGearQ || paramErrQ) begin
            pendQ <= '0;
        end else begin
            pendQ <= pendD;
        end
    end

    // encoder increment output and read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            encDeltaQ <= '0;
            encValidQ <= 1'b0;
            rdataQ    <= 32'h0000_0000;
            intStatQ  <= '0;
        end else begin
            encValidQ <= divBus.done;
            if (divBus.done) begin
                encDeltaQ <= divBus.quot;
            end
            rdataQ   <= regRd ? rdMux : 32'h0000_0000;
            intStatQ <= intStatD;
        end
    end

    assign regRdata            = rdataQ;
    assign multiplierActiveOut = multActiveQ;
    assign encDelta            = encDeltaQ;
    assign encValid            = encValidQ;
    assign paramError          = paramErrQ;
    assign irq                 = |(intStatQ & intMaskQ);

    sequence s_selOn;
        !utilBlock && selectIn;
    endsequence
    property p_sel_on;
        @(posedge clk) disable iff (!rst_n)
        s_selOn |=> multiplierActiveOut;
    endproperty
    a_sel_on: assert property (p_sel_on)
        else $error("multiplier not active after select on");

    property p_sel_off;
        @(posedge clk) disable iff (!rst_n)
        (!selectIn && !utilBlock) ##1 (!selectIn && !utilBlock)
        |-> !multiplierActiveOut && (factor == rps_pkg::MULT_MIN);
    endproperty
    a_sel_off: assert property (p_sel_off)
        else $error("multiplier still active after select off");

    property p_util_block;
        @(posedge clk) disable iff (!rst_n)
        utilBlock |=> !multiplierActiveOut;
    endproperty
    a_util_block: assert property (p_util_block)
        else $error("select honoured while a utility runs");

    property p_mult_wr;
        @(posedge clk) disable iff (!rst_n)
        (wrMult && multOk) |=> (multValueQ == $past(regWdata[6:0]));
    endproperty
    a_mult_wr: assert property (p_mult_wr)
        else $error("multiplier value write not taken");

    property p_mult_bad;
        @(posedge clk) disable iff (!rst_n)
        (wrMult && !multOk) |=> $stable(multValueQ);
    endproperty
    a_mult_bad: assert property (p_mult_bad)
        else $error("out-of-range multiplier value taken");

    property p_pulse_units;
        @(posedge clk) disable iff (!rst_n)
        (refPulse && !refDir && !divStart && !pendOvf &&
         !loadGearQ && !paramErrQ)
        |=> (pendQ == $past(pendQ) + 16'($past(factor)));
    endproperty
    a_pulse_units: assert property (p_pulse_units)
        else $error("pulse did not add the multiplier in units");

    property p_num_hold;
        @(posedge clk) disable iff (!rst_n)
        (wrNum && !loadGearQ) |=> $stable(numActQ);
    endproperty
    a_num_hold: assert property (p_num_hold)
        else $error("numerator applied without restart");

    property p_ratio_err;
        @(posedge clk) disable iff (!rst_n)
        ##1 (paramError == !$past(ratioOk));
    endproperty
    a_ratio_err: assert property (p_ratio_err)
        else $error("parameter error does not match ratio window");

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        (events[rps_pkg::EV_SWITCH] && clrBits[rps_pkg::EV_SWITCH])
        |=> intStatQ[rps_pkg::EV_SWITCH];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("switch event lost against clear");

    // restart and error paths flush the pending units, so a stale batch
    // never starts on a new gear; one already in the divider runs on with the new den
    property p_pend_clear;
        @(posedge clk) disable iff (!rst_n)
        (loadGearQ || paramErrQ) |=> (pendQ == 16'sh0000);
    endproperty
    a_pend_clear: assert property (p_pend_clear)
        else $error("pending units kept across restart or error");

    property p_load_gear;
        @(posedge clk) disable iff (!rst_n)
        loadGearQ |=> (numActQ == $past(numStageQ)) &&
                      (denActQ == $past(denStageQ));
    endproperty
    a_load_gear: assert property (p_load_gear)
        else $error("restart did not apply the staged gear");

    property p_err_rise;
        @(posedge clk) disable iff (!rst_n)
        (!ratioOk && !paramErrQ) |=> paramError && intStatQ[0];
    endproperty
    a_err_rise: assert property (p_err_rise)
        else $error("ratio error not raised or not flagged");

    sequence s_selRise;
        $rose(selectIn) && !utilBlock;
    endsequence
    property p_sel_rise;
        @(posedge clk) disable iff (!rst_n)
        s_selRise |=> multiplierActiveOut && intStatQ[1];
    endproperty
    a_sel_rise: assert property (p_sel_rise)
        else $error("select rise not confirmed on the active output");

    property p_pulse_down;
        @(posedge clk) disable iff (!rst_n)
        (refPulse && refDir && !divStart && !pendOvf &&
         !loadGearQ && !paramErrQ)
        |=> (pendQ == $past(pendQ) - 16'($past(factor)));
    endproperty
    a_pulse_down: assert property (p_pulse_down)
        else $error("reverse pulse did not subtract the multiplier");

    // divider answers reach the outputs exactly one cycle later
    property p_enc_out;
        @(posedge clk) disable iff (!rst_n)
        divBus.done |=> encValid && (encDelta == $past(divBus.quot));
    endproperty
    a_enc_out: assert property (p_enc_out)
        else $error("divider answer not passed to the encoder output");

    property p_enc_quiet;
        @(posedge clk) disable iff (!rst_n)
        !divBus.done |=> !encValid;
    endproperty
    a_enc_quiet: assert property (p_enc_quiet)
        else $error("encoder increment flagged without an answer");
endmodule

// ### rps_host_model.sv
// rps_host_model: host pulse-train controller facing the scaler.
// assumes: send is called right after a rising clk edge.
module rps_host_model (
    input  wire logic clk,               // drive clock
    input  wire logic activeIn,          // multiplier applied
    output logic      refPulse = 1'b0,   // one reference pulse
    output logic      refDir = 1'b0,     // direction, inverted when idle
    output logic      selectIn = 1'b0    // multiplier select level
);
    timeunit 1ns;
    timeprecision 1ps;
    // select first and wait for the answer, then pulses spaced by gap
    task automatic send(input logic sel, input int cnt, input logic dir,
                        input int gap);
        if (sel !== selectIn) begin
            selectIn <= sel;
            @(posedge clk);
            while (activeIn !== sel) @(posedge clk);
        end
        for (int i = 0; i < cnt; i++) begin
            refPulse <= 1'b1;
            refDir   <= dir;
            @(posedge clk);
            // a stale direction level would hide a missed sample
            if (gap > 0 || i == cnt - 1) begin
                refPulse <= 1'b0;
                refDir   <= ~dir;
                repeat (gap) @(posedge clk);
            end
        end
    endtask
endmodule

// ### rps_reference_pulse_scaler_tb.sv
// rps_reference_pulse_scaler_tb: self-checking bench of the scaler.
// assumes: package, interface, divider, scaler, host model come first.
module rps_reference_pulse_scaler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // bench inputs, model pins, observed outputs and tallies
    logic        clk, rst_n, progJogRun, autoTuneRun, regWr, regRd, irq;
    logic        refPulse, refDir, selectIn, encValid, paramError;
    logic        multiplierActiveOut;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic signed [47:0] encDelta, sum;
    int          errCount = 0, nCompared = 0;
    // expected tables: reset readback, multiplier writes, gear limits
    logic [3:0]  rstA[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
    logic [3:0]  rstV[8] = '{4'h0, 4'h1, 4'h4, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [31:0] mIn[4]  = '{32'h0, 32'h65, 32'h64, 32'h80};
    logic [31:0] mExp[4] = '{32'h1, 32'h1, 32'h64, 32'h64};
    logic [31:0] gNum[4] = '{32'hfa0, 32'hfa1, 32'h1, 32'h1};
    logic [31:0] gDen[4] = '{32'h1, 32'h1, 32'h3e8, 32'h3e9};
    logic [47:0] rExp[4] = '{48'h0, 48'h0, 48'h1, 48'hffff_ffff_ffff};
    logic [3:0]  gErr = 4'ha, rDir = 4'h8;
    rps_reference_pulse_scaler u_dut (
        .clk(clk), .rst_n(rst_n), .refPulse(refPulse), .refDir(refDir),
        .selectIn(selectIn), .progJogRun(progJogRun),
        .autoTuneRun(autoTuneRun), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .multiplierActiveOut(multiplierActiveOut), .encDelta(encDelta),
        .encValid(encValid), .paramError(paramError), .irq(irq)
    );
    rps_host_model u_host (
        .clk(clk), .activeIn(multiplierActiveOut), .refPulse(refPulse),
        .refDir(refDir), .selectIn(selectIn)
    );
    // 25 MHz drive clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // one access; read data stand only in the cycle after the strobe
    task automatic reg_acc(input logic w, input logic [3:0] a,
                           input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= w;
        regRd    <= !w;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(posedge clk);
        rd = regRdata;
    endtask
    // one counted comparison, a mismatch is reported at once
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // batches split unpredictably, so add up every increment in a window
    task automatic drain();
        sum = '0;
        repeat (300) begin
            @(posedge clk);
            if (encValid === 1'b1)
                sum = sum + encDelta;
        end
    endtask
    // verdict and end of run
    task automatic wrapUp();
        if (errCount == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, far beyond the roughly 2800 cycles of the tests
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        wrapUp();
    end
    // main sequence
    initial begin
        {rst_n, progJogRun, autoTuneRun, regWr, regRd, regAddr, regWdata} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset readback, unmapped index reads zero
        foreach (rstA[i]) begin
            reg_acc(1'b0, rstA[i], 32'h0);
            chk(48'(rd), 48'(rstV[i]));
        end
        // default gear 4/1 with the multiplier off, pulses back to back
        u_host.send(1'b0, 3, 1'b0, 0);
        drain();
        chk(sum, 48'hc);
        // out-of-range multiplier writes keep the old value
        foreach (mIn[i]) begin
            reg_acc(1'b1, 4'h1, mIn[i]);
            reg_acc(1'b0, 4'h1, 32'h0);
            chk(48'(rd), 48'(mExp[i]));
        end
        // select on: 100 units per pulse, slow host, then interrupt path
        u_host.send(1'b1, 2, 1'b0, 2);
        drain();
        chk(sum, 48'h320);
        chk(48'(multiplierActiveOut), 48'h1);
        chk(48'(irq), 48'h0);
        reg_acc(1'b1, 4'h6, 32'h2);
        chk(48'(irq), 48'h1);
        reg_acc(1'b1, 4'h5, 32'h2);
        chk(48'(irq), 48'h0);
        // either utility forces factor 1 though select stays high
        for (int u = 0; u < 2; u++) begin
            progJogRun  <= (u == 0);
            autoTuneRun <= (u == 1);
            // the clear lands on the switch edge for the first utility,
            // where the new event must win
            reg_acc(1'b1, 4'h5, 32'h2);
            chk(48'(irq), 48'(u == 0));
            chk(48'(multiplierActiveOut), 48'h0);
            u_host.send(1'b1, 1, 1'b0, 0);
            drain();
            chk(sum, 48'h4);
        end
        {progJogRun, autoTuneRun} <= 2'h0;
        // staged 1/3 waits for restart, then the remainder carries over
        reg_acc(1'b1, 4'h2, 32'h1);
        reg_acc(1'b1, 4'h3, 32'h3);
        u_host.send(1'b0, 1, 1'b0, 0);
        drain();
        chk(sum, 48'h4);
        reg_acc(1'b1, 4'h0, 32'h1);
        repeat (4) @(posedge clk);
        foreach (rExp[i]) begin
            u_host.send(1'b0, 1, rDir[i], 0);
            drain();
            chk(sum, rExp[i]);
        end
        // ratio limits are inclusive at both ends
        foreach (gNum[i]) begin
            reg_acc(1'b1, 4'h2, gNum[i]);
            reg_acc(1'b1, 4'h3, gDen[i]);
            reg_acc(1'b1, 4'h0, 32'h1);
            repeat (4) @(posedge clk);
            chk(48'(paramError), 48'(gErr[i]));
        end
        wrapUp();
    end
endmodule
